// [src/sats_ctrl.sv]
/*
  control logic of an eight channel successive approximation converter with a
  die temperature sensor: serial frame engine, channel sequencer, sar stepping,
  temperature integration timing and power-down / reset pin handling.
  assumes the analog comparator, dac and track-and-hold sit outside and that the
  serial pins come from a host in another clock domain.
*/
`timescale 1ns/1ps
module sats_ctrl #(
  parameter int MEAS_CYC = sats_pkg::MEAS_CYC
) (
  input  wire logic        i_clk,
  input  wire logic        i_resetn,
  input  wire logic        i_cs_n,
  input  wire logic        i_sclk,
  input  wire logic        i_din,
  input  wire logic        i_powerdown_reset_pin_n,
  input  wire logic        i_cmp,
  output logic             o_dout,
  output logic             o_dout_oe,
  output logic             o_hold,
  output logic [3:0]       o_mux_sel,
  output logic [11:0]      o_sar_dac,
  output logic             o_temp_busy,
  output logic             o_temp_integrate,
  output logic             o_full_powerdown,
  output logic             o_partial_powerdown,
  output logic             o_ext_ref
);

  localparam int TW = $clog2(MEAS_CYC + 1);

  // two-stage synchronisers for cs, sclk, din, pd pin and comparator
  logic [4:0] meta;
  logic [4:0] sync;
  logic [4:0] pins;
  assign pins = {i_cmp, i_powerdown_reset_pin_n, i_din, i_sclk, i_cs_n};

  genvar g;
  generate
    for (g = 0; g < 5; g++) begin : g_sync
      always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
          meta[g] <= (g == 4) ? 1'b0 : 1'b1;
          sync[g] <= (g == 4) ? 1'b0 : 1'b1;
        end else begin
          meta[g] <= pins[g];
          sync[g] <= meta[g];
        end
      end
    end
  endgenerate

  logic cs_n_s, sclk_s, din_s, pd_n_s, cmp_s;
  assign cs_n_s = sync[0];
  assign sclk_s = sync[1];
  assign din_s  = sync[2];
  assign pd_n_s = sync[3];
  assign cmp_s  = sync[4];

  logic cs_d, sclk_d, pd_d;
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      cs_d   <= 1'b1;
      sclk_d <= 1'b1;
      pd_d   <= 1'b1;
    end else begin
      cs_d   <= cs_n_s;
      sclk_d <= sclk_s;
      pd_d   <= pd_n_s;
    end
  end

  logic cs_fall, cs_rise, sclk_fall, pd_rise;
  assign cs_fall   = cs_d & ~cs_n_s;
  assign cs_rise   = ~cs_d & cs_n_s;
  assign sclk_fall = sclk_d & ~sclk_s & ~cs_n_s;
  assign pd_rise   = ~pd_d & pd_n_s;

  // power-down / reset pin: length of the low level decides
  logic [7:0] pd_cnt;
  logic       soft_rst;
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      pd_cnt           <= 8'h00;
      soft_rst         <= 1'b0;
      o_full_powerdown <= 1'b0;
    end else begin
      soft_rst <= 1'b0;
      if (!pd_n_s) begin
        if (pd_cnt <= 8'(sats_pkg::RST_MAX_CYC))
          pd_cnt <= pd_cnt + 8'h01;
        if (pd_cnt > 8'(sats_pkg::RST_MAX_CYC))
          o_full_powerdown <= 1'b1;
      end else if (pd_rise) begin
        soft_rst         <= (pd_cnt >= 8'(sats_pkg::RST_MIN_CYC)) &&
                            (pd_cnt <= 8'(sats_pkg::RST_MAX_CYC));
        o_full_powerdown <= 1'b0;
        pd_cnt           <= 8'h00;
      end
    end
  end

  logic active;
  assign active = ~o_full_powerdown & ~soft_rst;

  // serial frame: shift result out, configuration in
  logic [4:0]  bit_cnt;
  logic [15:0] shift_out;
  logic [15:0] shift_in;
  logic [15:0] cfg;
  logic [3:0]  pend_addr;
  logic [11:0] pend_data;
  logic        cfg_load;
  assign cfg_load = cs_rise && bit_cnt == 5'(sats_pkg::FRAME_BITS) &&
                    shift_in[sats_pkg::CFG_WRITE] && active;

  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      bit_cnt   <= 5'h00;
      shift_out <= 16'h0000;
      shift_in  <= 16'h0000;
      o_dout    <= 1'b0;
      o_dout_oe <= 1'b0;
    end else begin
      o_dout_oe <= ~cs_n_s & ~o_full_powerdown;
      if (cs_fall) begin
        bit_cnt   <= 5'h00;
        o_dout    <= pend_addr[3];
        shift_out <= {pend_addr[2:0], pend_data, 1'b0};
      end else if (sclk_fall && bit_cnt < 5'(sats_pkg::FRAME_BITS)) begin
        bit_cnt   <= bit_cnt + 5'h01;
        shift_in  <= {shift_in[14:0], din_s};
        o_dout    <= shift_out[15];
        shift_out <= {shift_out[14:0], 1'b0};
      end
    end
  end

  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn)
      cfg <= sats_pkg::CFG_RESET;
    else if (soft_rst)
      cfg <= sats_pkg::CFG_RESET;
    else if (cfg_load)
      cfg <= shift_in;
  end

  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_partial_powerdown <= 1'b0;
      o_ext_ref           <= 1'b0;
    end else begin
      o_partial_powerdown <= cfg[sats_pkg::CFG_PPD] & cs_n_s & ~o_temp_busy &
                             ~o_full_powerdown;
      o_ext_ref           <= cfg[sats_pkg::CFG_EXT_REF];
    end
  end

  // channel mask: channel 0 is the highest of the eight select bits
  logic [7:0] ch_mask;
  generate
    for (g = 0; g < sats_pkg::NUM_CH; g++) begin : g_mask
      assign ch_mask[g] = cfg[sats_pkg::CFG_CH0 - g];
    end
  endgenerate

  function automatic logic [2:0] next_ch(input logic [2:0] cur, input logic [7:0] mask);
    logic [2:0] r;
    logic [2:0] c;
    logic       found;
    r     = 3'h0;
    found = 1'b0;
    for (int k = 1; k <= sats_pkg::NUM_CH; k++) begin
      c = cur + 3'(k);
      if (!found && mask[c]) begin
        r     = c;
        found = 1'b1;
      end
    end
    return r;
  endfunction

  sats_pkg::sats_state_type state;
  logic [2:0]  cur_ch;
  logic [2:0]  nxt_ch;
  logic        temp_done;
  logic        temp_go;
  logic        go;
  logic [3:0]  sar_bit;
  logic [11:0] trial;
  logic        sar_step;
  logic        sar_last;
  logic [TW-1:0] timer;

  assign nxt_ch   = next_ch(cur_ch, ch_mask);
  assign go       = cs_fall & active & (state == sats_pkg::ST_IDLE);
  assign temp_go  = cfg[sats_pkg::CFG_TSENSE] & (nxt_ch <= cur_ch) & ~temp_done;
  assign sar_step = sclk_fall & ~soft_rst &
                    (state == sats_pkg::ST_VCONV || state == sats_pkg::ST_TCONV);
  assign sar_last = sar_bit == 4'h0;
  // keep the trial bit only when the input is at or above the dac level
  assign trial    = cmp_s ? o_sar_dac : (o_sar_dac & ~(12'h001 << sar_bit));

  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      state            <= sats_pkg::ST_IDLE;
      cur_ch           <= 3'h7;
      temp_done        <= 1'b0;
      sar_bit          <= 4'h0;
      timer            <= '0;
      o_hold           <= 1'b0;
      o_mux_sel        <= 4'h0;
      o_sar_dac        <= 12'h000;
      o_temp_busy      <= 1'b0;
      o_temp_integrate <= 1'b0;
      pend_addr        <= 4'h0;
      pend_data        <= 12'h000;
    end else if (soft_rst) begin
      state            <= sats_pkg::ST_IDLE;
      cur_ch           <= 3'h7;
      temp_done        <= 1'b0;
      o_hold           <= 1'b0;
      o_temp_busy      <= 1'b0;
      o_temp_integrate <= 1'b0;
    end else begin
      if (cfg_load) begin
        cur_ch    <= 3'h7;
        temp_done <= 1'b0;
      end
      unique case (state)
        sats_pkg::ST_IDLE: begin
          if (go && temp_go) begin
            temp_done        <= 1'b1;
            o_mux_sel        <= sats_pkg::TEMP_ADDR;
            o_temp_busy      <= 1'b1;
            o_temp_integrate <= 1'b1;
            timer            <= '0;
            state            <= sats_pkg::ST_TINT;
          end else if (go) begin
            temp_done <= 1'b0;
            cur_ch    <= nxt_ch;
            o_mux_sel <= {1'b0, nxt_ch};
            o_hold    <= 1'b1;
            o_sar_dac <= sats_pkg::SAR_START;
            sar_bit   <= 4'(sats_pkg::RES_W - 1);
            state     <= sats_pkg::ST_VCONV;
          end
        end
        sats_pkg::ST_TINT: begin
          timer <= timer + TW'(1);
          if (timer == TW'(MEAS_CYC - 1)) begin
            o_temp_integrate <= 1'b0;
            o_hold           <= 1'b1;
            o_sar_dac        <= sats_pkg::SAR_START;
            sar_bit          <= 4'(sats_pkg::RES_W - 1);
            state            <= sats_pkg::ST_TCONV;
          end
        end
        sats_pkg::ST_VCONV, sats_pkg::ST_TCONV: begin
          if (state == sats_pkg::ST_VCONV && cs_rise) begin
            o_hold <= 1'b0;
            state  <= sats_pkg::ST_IDLE;
          end else if (sar_step && !sar_last) begin
            o_sar_dac <= trial | (12'h001 << (sar_bit - 4'h1));
            sar_bit   <= sar_bit - 4'h1;
          end else if (sar_step) begin
            o_sar_dac <= trial;
            pend_addr <= o_mux_sel;
            if (state == sats_pkg::ST_TCONV)
              pend_data <= trial ^ sats_pkg::TEMP_FLIP;
            else
              pend_data <= trial;
            o_hold      <= 1'b0;
            o_temp_busy <= 1'b0;
            state       <= sats_pkg::ST_IDLE;
          end
        end
      endcase
    end
  end

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_resetn);

  sequence s_vstart;
    go && !temp_go;
  endsequence
  sequence s_tstart;
    go && temp_go;
  endsequence
  sequence s_last_step;
    sar_step && sar_last && !(state == sats_pkg::ST_VCONV && cs_rise);
  endsequence

  seq_advance_a: assert property (s_vstart |=> cur_ch == $past(nxt_ch) &&
    o_mux_sel == {1'b0, $past(nxt_ch)}) else $error("sequencer did not advance");
  sar_clocked_a: assert property (state == sats_pkg::ST_VCONV && !sclk_fall &&
    !soft_rst |=> $stable(o_sar_dac)) else $error("sar moved without a serial clock fall");
  pipe_latency_a: assert property (cs_fall |=> o_dout == $past(pend_addr[3]))
    else $error("frame did not start with pending address");
  ppd_gate_a: assert property (o_partial_powerdown |-> $past(cfg[sats_pkg::CFG_PPD])
    && $past(cs_n_s)) else $error("partial power-down without its bit");
  temp_coding_a: assert property (s_last_step ##0 state == sats_pkg::ST_TCONV
    |=> pend_data == ($past(trial) ^ sats_pkg::TEMP_FLIP)) else $error("temperature coding");
  volt_coding_a: assert property (s_last_step ##0 state == sats_pkg::ST_VCONV
    |=> pend_data == $past(trial) && !o_hold) else $error("voltage coding or track");
  temp_start_a: assert property (s_tstart |=> o_temp_busy && o_temp_integrate
    ##0 state == sats_pkg::ST_TINT) else $error("integration did not start");
  auto_conv_a: assert property (state == sats_pkg::ST_TINT && !soft_rst &&
    timer == TW'(MEAS_CYC - 1) |=> state == sats_pkg::ST_TCONV && !o_temp_integrate
    && o_temp_busy) else $error("conversion did not follow integration");
  busy_span_a: assert property (o_temp_busy |-> state == sats_pkg::ST_TINT ||
    state == sats_pkg::ST_TCONV) else $error("busy outside temperature measurement");
  temp_select_a: assert property ($rose(o_temp_busy) |->
    $past(cfg[sats_pkg::CFG_TSENSE])) else $error("temperature without select bit");
  hold_start_a: assert property (s_vstart |=> o_hold ##1 o_hold)
    else $error("hold not taken at chip-select fall");
  shift_order_a: assert property (sclk_fall && bit_cnt < 5'(sats_pkg::FRAME_BITS)
    |=> o_dout == $past(shift_out[15])) else $error("serial output order");
  cfg_load_a: assert property (cfg_load && !soft_rst |=> cfg == $past(shift_in))
    else $error("configuration not loaded");
  pd_long_a: assert property (!pd_n_s && pd_cnt > 8'(sats_pkg::RST_MAX_CYC)
    |=> o_full_powerdown) else $error("long low did not power down");

endmodule

// [src/sats_pkg.sv]
/*
  constants shared by the converter sequencer control: configuration word layout,
  frame geometry, result coding and timing counts.
  assumes a 200 MHz system clock; every pin but the asynchronous reset is sampled by that clock.
*/
package sats_pkg;

  // configuration word, first bit on the serial input is the msb
  localparam int          CFG_W         = 16;
  localparam int          CFG_WRITE     = 15;
  localparam int          CFG_REPEAT    = 14;
  localparam int          CFG_CH0       = 13;
  localparam int          CFG_TSENSE    = 5;
  localparam int          CFG_EXT_REF   = 2;
  localparam int          CFG_AVG       = 1;
  localparam int          CFG_PPD       = 0;
  localparam logic [15:0] CFG_RESET     = 16'h0000;

  // converter geometry
  localparam int          NUM_CH        = 8;
  localparam int          FULL_SCALE    = 4096;
  localparam int          RES_W         = $clog2(FULL_SCALE);
  localparam int          ADDR_W        = 4;
  localparam int          FRAME_BITS    = ADDR_W + RES_W;
  localparam logic [3:0]  TEMP_ADDR     = 4'h8;
  localparam logic [11:0] SAR_START     = 12'h800;
  localparam logic [11:0] TEMP_FLIP     = 12'h800;

  // timing
  localparam int          CLK_MHZ       = 200;
  localparam int          CLK_PERIOD_NS = 5;
  localparam int          MEAS_TIME_US  = 100;
  localparam int          MEAS_CYC      = MEAS_TIME_US * CLK_MHZ;
  localparam int          RST_MIN_NS    = 1;
  localparam int          RST_MIN_CYC   = (RST_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int          RST_MAX_NS    = 100;
  localparam int          RST_MAX_CYC   = RST_MAX_NS / CLK_PERIOD_NS;

  typedef enum logic [1:0] {
    ST_IDLE  = 2'b00,
    ST_VCONV = 2'b01,
    ST_TINT  = 2'b10,
    ST_TCONV = 2'b11
  } sats_state_type;

endpackage

// [bench/sats_host.sv]
/*
  host serial controller model: frames one 16 bit word and reads one back.
  assumes the converter samples these pins with its own faster clock.
*/
`timescale 1ns/1ps
module sats_host (
  input  wire logic i_dout,
  output logic      o_cs_n,
  output logic      o_sclk,
  output logic      o_din
);
  initial begin
    o_cs_n = 1'b1;
    o_sclk = 1'b1;
    o_din  = 1'b0;
  end

  // clock stands high between frames; din moves after rises, dout taken before falls
  task automatic frame(input logic [15:0] w, output logic [15:0] d);
    // half-nanosecond offset keeps every pin move off the converter's sampling edges
    #3.5 o_cs_n = 1'b0;
    o_din = w[15];
    for (int i = 15; i >= 0; i--) begin
      #32 d[i] = i_dout;
      o_sclk = 1'b0;
      #32 o_sclk = 1'b1;
      if (i > 0) begin
        o_din = w[i-1];
      end
    end
    #32 o_cs_n = 1'b1;
    // released line shows the opposite level so stale data cannot pass
    o_din = ~o_din;
  endtask
endmodule

// [bench/sats_ctrl_bench.sv]
/*
  testbench for the converter sequencer control: voltage sequence, temperature
  measurement, power-down pin. assumes the host model and a comparator stand-in.
*/
`timescale 1ns/1ps
module sats_ctrl_bench;
  localparam int MC = 50;
  logic        i_clk;
  logic        i_resetn;
  logic        i_pd_n;
  logic        i_cmp;
  logic        cs_n;
  logic        sclk;
  logic        din;
  logic        dout;
  logic        oe;
  logic        hold;
  logic        busy;
  logic        integ;
  logic        fpd;
  logic        partial_powerdown_bit;
  logic        xref;
  logic [3:0]  mux;
  logic [11:0] dac;
  logic [11:0] vin [0:8];
  logic [15:0] rx;
  int          n_mismatch;
  int          n_checks;

  sats_ctrl #(.MEAS_CYC(MC)) DUT (.i_clk(i_clk), .i_resetn(i_resetn), .i_cs_n(cs_n),
    .i_sclk(sclk), .i_din(din), .i_powerdown_reset_pin_n(i_pd_n), .i_cmp(i_cmp),
    .o_dout(dout), .o_dout_oe(oe), .o_hold(hold), .o_mux_sel(mux), .o_sar_dac(dac),
    .o_temp_busy(busy), .o_temp_integrate(integ), .o_full_powerdown(fpd),
    .o_partial_powerdown(partial_powerdown_bit), .o_ext_ref(xref));
  sats_host host (.i_dout(dout), .o_cs_n(cs_n), .o_sclk(sclk), .o_din(din));

  initial begin
    i_clk = 1'b0;
    forever #2.5 i_clk = ~i_clk;
  end

  // comparator stand-in: selected input level against the trial code
  always @(posedge i_clk) begin
    i_cmp <= (vin[mux] >= dac);
  end

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    n_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic complete_run();
    $display("checks=%0d mismatches=%0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  // one frame; chk also looks at the track-and-hold of a voltage conversion
  task automatic frm(input logic [15:0] w, input logic chk);
    fork
      host.frame(w, rx);
      begin
        #201 check(oe, {i_pd_n});
        if (chk) check(hold, 1'b1);
      end
    join
    repeat (5) @(posedge i_clk);
    if (chk) check(hold, 1'b0);
    check(oe, 1'b0);
  endtask

  task automatic t_seq();
    logic [3:0] exp_ch [0:4];
    exp_ch = '{4'h0, 4'h1, 4'h2, 4'h5, 4'h1};
    frm(16'h9904, 1'b1);
    check(xref, 1'b1);
    check(dac, vin[0]);
    for (int f = 0; f < 5; f++) begin
      frm(16'h0000, 1'b1);
      check(rx, {exp_ch[f], vin[exp_ch[f]]});
      check(busy, 1'b0);
    end
  endtask

  task automatic t_temp();
    logic seen;
    logic got;
    seen = 1'b0;
    got  = 1'b0;
    frm(16'h8421, 1'b1);
    check(partial_powerdown_bit, 1'b1);
    for (int f = 0; f < 4 && !seen; f++) begin
      fork
        host.frame(16'h0000, rx);
        for (int c = 0; c < 60 && !seen; c++) begin
          @(posedge i_clk);
          if (busy === 1'b1) begin
            seen = 1'b1;
            check({integ, mux}, {1'b1, sats_pkg::TEMP_ADDR});
            repeat (MC - 5) @(posedge i_clk);
            check(integ, 1'b1);
            repeat (15) @(posedge i_clk);
            check({integ, busy, partial_powerdown_bit}, 3'b010);
          end
        end
      join
      repeat (5) @(posedge i_clk);
    end
    check(seen, 1'b1);
    for (int f = 0; f < 4 && busy === 1'b1; f++) frm(16'h0000, 1'b0);
    check(busy, 1'b0);
    for (int f = 0; f < 10 && !got; f++) begin
      frm(16'h0000, 1'b0);
      if (rx[15:12] === sats_pkg::TEMP_ADDR) begin
        got = 1'b1;
        check(rx[11:0], 12'hF60);
      end
    end
    if (!got) begin
      check(got, 1'b1);
      complete_run();
    end
  endtask

  task automatic t_pin();
    check(partial_powerdown_bit, 1'b1);
    i_pd_n <= 1'b0;
    repeat (10) @(posedge i_clk);
    i_pd_n <= 1'b1;
    repeat (8) @(posedge i_clk);
    check({partial_powerdown_bit, fpd}, 2'b00);
    i_pd_n <= 1'b0;
    repeat (40) @(posedge i_clk);
    check(fpd, 1'b1);
    frm(16'h8001, 1'b0);
    i_pd_n <= 1'b1;
    repeat (8) @(posedge i_clk);
    check({fpd, partial_powerdown_bit}, 2'b00);
  endtask

  initial begin
    n_mismatch = 0;
    n_checks   = 0;
    i_resetn   = 1'b0;
    i_pd_n     = 1'b1;
    vin        = '{12'h3C5, 12'h000, 12'hFFF, 12'h5A3, 12'h0F0,
                   12'h801, 12'h111, 12'h222, 12'h760};
    repeat (5) @(posedge i_clk);
    check({oe, hold, busy, integ, fpd, partial_powerdown_bit, xref, mux}, 15'h0000);
    check({dout, dac}, 16'h0000);
    i_resetn <= 1'b1;
    repeat (5) @(posedge i_clk);
    t_seq();
    t_temp();
    t_pin();
    complete_run();
  end
endmodule
